// ===== tb/ctpwm_event_src.sv
`timescale 1ns/1ps
`default_nettype none
module ctpwm_event_src (
	input  wire logic       clk,     // bench clock
	input  wire logic       reset_n, // synchronous reset
	input  wire logic       go,      // start a burst
	input  wire logic [3:0] pulses,  // falling edges per burst
	output logic            ev_pin   // event pin, idles high
);
	logic [3:0] left_q;
	logic [2:0] ph_q;

	// ======================================================
	// pulse burst: each level three cycles, above the minimum
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			left_q <= 4'h0;
			ph_q   <= 3'h0;
			ev_pin <= 1'b1;
		end else if (go && left_q == 4'h0) begin
			left_q <= pulses;
			ph_q   <= 3'h0;
		end else if (left_q != 4'h0) begin
			ph_q   <= (ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
			ev_pin <= (ph_q < 3'h3) ? 1'b0 : 1'b1;
			if (ph_q == 3'h5)
				left_q <= left_q - 4'h1;
		end
	end
endmodule
`default_nettype wire

// ===== tb/ctpwm_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ctpwm_top_tb;
	logic       clk = 1'b0;
	logic       reset_n = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic       wr_en = 1'b0;
	logic       rd_en = 1'b0;
	logic [7:0] rdata;
	logic       ev_pin;
	logic       fs_clk = 1'b0;
	logic       lsm = 1'b0;
	logic       pwm_out;
	logic       match_irq;
	logic       ev_go = 1'b0;
	logic [3:0] ev_n = 4'h0;
	int         fail_count = 0;
	int         checks_done = 0;
	int         cyc = 0;
	int         irq_cnt = 0;
	int         irq_t = 0;
	int         fs_div = 0;
	// timer rows: lower ctl, low speed, compare, irq spacing
	logic [7:0]  t_lc [6] = '{8'h00, 8'h10, 8'h00, 8'h01, 8'h02, 8'h03};
	logic        t_ls [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
	logic [15:0] t_cmp[6] = '{16'h0, 16'h0, 16'h0, 16'h1, 16'h2, 16'h0101};
	int          t_per[6] = '{2048, 48, 48, 256, 96, 2064};

	ctpwm_top i_dut (.clk(clk), .reset_n(reset_n), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.event_in(ev_pin), .low_freq_clock(fs_clk),
		.low_speed_mode(lsm), .pwm_out(pwm_out), .match_irq(match_irq));
	ctpwm_event_src i_src (.clk(clk), .reset_n(reset_n), .go(ev_go),
		.pulses(ev_n), .ev_pin(ev_pin));

	// ======================================================
	// clocks; slow clock is six fast cycles per period
	always #5 clk = ~clk;
	always @(posedge clk) begin
		fs_div <= (fs_div == 2) ? 0 : fs_div + 1;
		if (fs_div == 2)
			fs_clk <= ~fs_clk;
	end
	// interrupt monitor, cycle stamp of the latest pulse
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (match_irq === 1'b1) begin
			irq_cnt <= irq_cnt + 1;
			irq_t   <= cyc;
		end
	end

	// ======================================================
	// access and check tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		rd_en <= 1'b1;
		addr  <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		chk(16'(rdata), 16'(e));
	endtask
	task automatic w16(input logic [3:0] a, input logic [15:0] v);
		wr(a, v[7:0]);
		wr(a + 4'h1, v[15:8]);
	endtask
	task automatic wait_irq(input int lim);
		int c0;
		int i;
		c0 = irq_cnt;
		for (i = 0; i < lim && irq_cnt == c0; i++)
			@(posedge clk);
		chk(16'(irq_cnt != c0), 16'h0001);
	endtask
	task automatic wait_pwm(input logic lv, output int n);
		n = 0;
		while (pwm_out !== lv && n < 70000) begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic chk_pwm(input logic lv);
		repeat (3) @(posedge clk);
		chk(16'(pwm_out), 16'(lv));
	endtask
	task automatic send_ev(input logic [3:0] n);
		@(posedge clk);
		ev_go <= 1'b1;
		ev_n  <= n;
		@(posedge clk);
		ev_go <= 1'b0;
		repeat (6 * n + 5) @(posedge clk);
	endtask
	task automatic close_out();
		$display("checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ======================================================
	// watchdog against a hang
	initial begin
		repeat (95000) @(posedge clk);
		fail_count++;
		close_out();
	end

	// ======================================================
	// main sequence
	initial begin
		int i;
		int t0;
		int n;
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		chk_pwm(1'b1);
		rd(ctpwm_pkg::ADDR_UPPER_CTL, 8'h00);
		rd(ctpwm_pkg::ADDR_COUNT_LO, 8'h00);
		wr(4'hA, 8'hFF);
		rd(4'hA, 8'h00);
		// interval timer over every tap; stopped means silent
		for (i = 0; i < 6; i++) begin
			wr(ctpwm_pkg::ADDR_LOWER_CTL, t_lc[i]);
			lsm <= t_ls[i];
			w16(ctpwm_pkg::ADDR_CMP_LO, t_cmp[i]);
			wr(ctpwm_pkg::ADDR_UPPER_CTL, 8'h08);
			wait_irq(5000);
			t0 = irq_t;
			wait_irq(5000);
			chk(16'(irq_t - t0), 16'(t_per[i]));
			wr(ctpwm_pkg::ADDR_UPPER_CTL, 8'h00);
			repeat (3) @(posedge clk);
			n = irq_cnt;
			repeat (2100) @(posedge clk);
			chk(16'(irq_cnt), 16'(n));
		end
		// event counting, compare rewritten while stopped, match on the fourth edge
		wr(ctpwm_pkg::ADDR_LOWER_CTL, 8'h00);
		w16(ctpwm_pkg::ADDR_CMP_LO, 16'h00FF);
		wr(ctpwm_pkg::ADDR_UPPER_CTL, 8'h09);
		n = irq_cnt;
		send_ev(4'h3);
		chk(16'(irq_cnt), 16'(n));
		wr(ctpwm_pkg::ADDR_UPPER_CTL, 8'h01);
		w16(ctpwm_pkg::ADDR_CMP_LO, 16'h0003);
		wr(ctpwm_pkg::ADDR_UPPER_CTL, 8'h09);
		send_ev(4'h3);
		chk(16'(irq_cnt), 16'(n));
		send_ev(4'h1);
		chk(16'(irq_cnt), 16'(n + 1));
		wr(ctpwm_pkg::ADDR_UPPER_CTL, 8'h00);
		// wave on event clock, then stop and reload the flop
		wr(ctpwm_pkg::ADDR_LOWER_CTL, 8'h07);
		w16(ctpwm_pkg::ADDR_DUTY_LO, 16'h0002);
		wr(ctpwm_pkg::ADDR_UPPER_CTL, 8'h0A);
		send_ev(4'h1);
		chk_pwm(1'b1);
		send_ev(4'h2);
		chk_pwm(1'b0);
		wr(ctpwm_pkg::ADDR_UPPER_CTL, 8'h02);
		chk_pwm(1'b0);
		wr(ctpwm_pkg::ADDR_UPPER_CTL, 8'h02);
		chk_pwm(1'b1);
		wr(ctpwm_pkg::ADDR_UPPER_CTL, 8'h82);
		chk_pwm(1'b0);
		// wave on every clock: duty buffered until wrap
		wr(ctpwm_pkg::ADDR_LOWER_CTL, 8'h06);
		w16(ctpwm_pkg::ADDR_DUTY_LO, 16'h0100);
		t0 = cyc;
		wr(ctpwm_pkg::ADDR_UPPER_CTL, 8'h0A);
		chk_pwm(1'b1);
		wait_pwm(1'b0, n);
		chk(16'(n > 240 && n < 264), 16'h0001);
		rd(ctpwm_pkg::ADDR_DUTY_HI, 8'h01);
		w16(ctpwm_pkg::ADDR_DUTY_LO, 16'h0200);
		rd(ctpwm_pkg::ADDR_DUTY_HI, 8'h01);
		wait_irq(70000);
		chk(16'(irq_t - t0 > 65530 && irq_t - t0 < 65550), 16'h0001);
		chk_pwm(1'b1);
		rd(ctpwm_pkg::ADDR_DUTY_HI, 8'h02);
		wait_pwm(1'b0, n);
		chk(16'(n > 16'h1E8 && n < 16'h204), 16'h0001);
		// reset in mid-run clears flop and control
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		chk_pwm(1'b1);
		rd(ctpwm_pkg::ADDR_UPPER_CTL, 8'h00);
		close_out();
	end
endmodule
`default_nettype wire

// ===== verilog/ctpwm_pkg.sv
`default_nettype none
package ctpwm_pkg;
	// ======================================================
	// register map, word index on the plain register port
	localparam logic [3:0] ADDR_LOWER_CTL = 4'h0;
	localparam logic [3:0] ADDR_UPPER_CTL = 4'h1;
	localparam logic [3:0] ADDR_CMP_LO    = 4'h2;
	localparam logic [3:0] ADDR_CMP_HI    = 4'h3;
	localparam logic [3:0] ADDR_DUTY_LO   = 4'h4;
	localparam logic [3:0] ADDR_DUTY_HI   = 4'h5;
	localparam logic [3:0] ADDR_COUNT_LO  = 4'h6;
	localparam logic [3:0] ADDR_COUNT_HI  = 4'h7;

	// ======================================================
	// field positions
	localparam int LCTL_CLK_LSB   = 0; // three-bit clock select
	localparam int LCTL_DIV_STAGE = 4; // divider_stage_select
	localparam int UCTL_MODE_LSB  = 0; // two-bit mode
	localparam int UCTL_RUN       = 3; // run_bit
	localparam int UCTL_FF_INIT   = 7; // flip_flop_initial_bit

	// ======================================================
	// reset values and count top
	localparam logic [7:0]  CTL_RESET   = 8'h00;
	localparam logic [15:0] WORD_RESET  = 16'h0000;
	localparam logic [15:0] COUNT_TOP   = 16'hFFFF;

	// ======================================================
	// clock select codes
	localparam logic [2:0] CLK_SLOW_TAP = 3'h0; // fc/2^11 or fs/2^3
	localparam logic [2:0] CLK_FC_DIV7  = 3'h1;
	localparam logic [2:0] CLK_FC_DIV5  = 3'h2;
	localparam logic [2:0] CLK_FC_DIV3  = 3'h3;
	localparam logic [2:0] CLK_FS       = 3'h4; // wave mode only
	localparam logic [2:0] CLK_FC_DIV1  = 3'h5; // wave mode only
	localparam logic [2:0] CLK_FC       = 3'h6; // wave mode only
	localparam logic [2:0] CLK_EVENT    = 3'h7; // wave mode only

	// ======================================================
	// prescaler widths on the fast and slow clocks
	localparam int PRESC_W   = 11;
	localparam int FS_DIV_W  = 3;
	localparam logic [2:0] FS_DIV_LAST = 3'h7;

	// ======================================================
	// finest wave step and period at a 16 MHz fast clock
	localparam int WAVE_RES_PS    = 62500;
	localparam int WAVE_PERIOD_US = 4100;
	localparam int CLK_PERIOD_PS  = 10000;
	localparam int WAVE_RES_CYC   =
		(WAVE_RES_PS / CLK_PERIOD_PS < 1) ? 1 :
		WAVE_RES_PS / CLK_PERIOD_PS;

	// ======================================================
	// operating modes
	typedef enum logic [1:0] {
		CTPWM_TIMER = 2'h0,
		CTPWM_EVENT = 2'h1,
		CTPWM_WAVE  = 2'h2,
		CTPWM_IDLE  = 2'h3
	} ctpwm_mode_t;
endpackage
`default_nettype wire

// ===== verilog/ctpwm_top.sv
// Behaviour
// - two bytes chain into one 16-bit counter
// - run bit starts counting, clearing it stops
// - timer: match raises interrupt, clears, keeps counting
// - compare has no buffer, takes effect immediately
// - timer clock taps fc/2^11 or fs/2^3, 2^7, 2^5, 2^3
// - event mode counts falling edges, match clears
// - wave mode clocked internally or by event
// - wave: duty match toggles, overflow toggles and clears
// - flop loadable by software, reset clears it
// - wave pin is inverse of output flop
// - duty buffered while the wave runs, direct when stopped or in other modes
// - duty reads return active value
// - stopped pin holds, flop loaded on later write
// - wave mode adds fs, fc/2 and fc taps
`timescale 1ns/1ps
`default_nettype none
module ctpwm_top (
	input  wire logic       clk,           // 100 MHz fast clock
	input  wire logic       reset_n,       // synchronous reset
	input  wire logic [3:0] addr,          // register index
	input  wire logic [7:0] wdata,         // write data
	input  wire logic       wr_en,         // write strobe
	input  wire logic       rd_en,         // read strobe
	output logic      [7:0] rdata,         // read data, next cycle
	input  wire logic       event_in,      // event_input_pin
	input  wire logic       low_freq_clock,// slow clock level
	input  wire logic       low_speed_mode,// slow or sleep operation
	output logic            pwm_out,       // pulse_width_output_pin
	output logic            match_irq      // match_interrupt pulse
);
	// ======================================================
	// state
	typedef struct packed {
		logic [7:0]                     lctl_q;
		logic [7:0]                     uctl_q;
		logic [15:0]                    cmp_q;
		logic [15:0]                    dbuf_q;
		logic [15:0]                    dact_q;
		logic [15:0]                    cnt_q;
		logic                           ff_q;
		logic                           pin_q;
		logic                           irq_q;
		logic [7:0]                     rdata_q;
		logic [ctpwm_pkg::PRESC_W-1:0]  presc_q;
		logic [ctpwm_pkg::FS_DIV_W-1:0] fsdiv_q;
		logic                           fs_prev_q;
		logic                           ev_s1_q;
		logic                           ev_s2_q;
		logic                           ev_s3_q;
	} ctpwm_state_t;

	ctpwm_state_t st_q;
	ctpwm_state_t st_d;

	logic                  run;
	ctpwm_pkg::ctpwm_mode_t mode;
	logic [2:0]            clk_sel;
	logic                  fs_rise;
	logic                  ev_fall;
	logic [7:0]            taps;
	logic                  tick;
	logic                  cmp_hit;
	logic                  duty_hit;
	logic                  wrap;
	logic                  wr_upper;

	// decoded control fields and match detectors
	assign run      = st_q.uctl_q[ctpwm_pkg::UCTL_RUN];
	assign mode     = ctpwm_pkg::ctpwm_mode_t'(
		st_q.uctl_q[ctpwm_pkg::UCTL_MODE_LSB +: 2]);
	assign clk_sel  = st_q.lctl_q[ctpwm_pkg::LCTL_CLK_LSB +: 3];
	assign cmp_hit  = (st_q.cnt_q == st_q.cmp_q);
	assign duty_hit = (st_q.cnt_q == st_q.dact_q);
	assign wrap     = (st_q.cnt_q == ctpwm_pkg::COUNT_TOP);
	assign wr_upper = wr_en && (addr == ctpwm_pkg::ADDR_UPPER_CTL);

	// ======================================================
	// clock taps; fast-clock taps vanish in low-speed operation
	always_comb begin
		fs_rise = low_freq_clock && !st_q.fs_prev_q;
		// falling edge seen only on synchronised samples
		ev_fall = st_q.ev_s3_q && !st_q.ev_s2_q;
		taps[0] = (st_q.lctl_q[ctpwm_pkg::LCTL_DIV_STAGE]
			|| low_speed_mode)
			? (fs_rise && st_q.fsdiv_q == ctpwm_pkg::FS_DIV_LAST)
			: (&st_q.presc_q);
		taps[1] = !low_speed_mode && (&st_q.presc_q[6:0]);
		taps[2] = !low_speed_mode && (&st_q.presc_q[4:0]);
		taps[3] = !low_speed_mode && (&st_q.presc_q[2:0]);
		// wave-only taps follow; the plain timer masks them
		taps[4] = fs_rise;
		taps[5] = !low_speed_mode && st_q.presc_q[0];
		taps[6] = !low_speed_mode;
		taps[7] = ev_fall;
		unique case (mode)
			ctpwm_pkg::CTPWM_TIMER: begin
				// the wave-only taps do not drive the plain timer
				tick = !clk_sel[2] && taps[clk_sel];
			end
			ctpwm_pkg::CTPWM_EVENT: begin
				tick = ev_fall;
			end
			ctpwm_pkg::CTPWM_WAVE: begin
				tick = taps[clk_sel];
			end
			ctpwm_pkg::CTPWM_IDLE: begin
				tick = 1'b0;
			end
		endcase
	end

	// ======================================================
	// next state: counting, register writes, reads
	always_comb begin
		st_d           = st_q;
		st_d.irq_q     = 1'b0;
		st_d.presc_q   = st_q.presc_q + 1'b1;
		st_d.fs_prev_q = low_freq_clock;
		st_d.ev_s1_q   = event_in;
		st_d.ev_s2_q   = st_q.ev_s1_q;
		st_d.ev_s3_q   = st_q.ev_s2_q;
		if (fs_rise) begin
			st_d.fsdiv_q = st_q.fsdiv_q + 1'b1;
		end

		// counter: cleared while stopped so each start begins at zero
		if (!run) begin
			st_d.cnt_q = ctpwm_pkg::WORD_RESET;
		end else if (tick) begin
			unique case (mode)
				ctpwm_pkg::CTPWM_TIMER,
				ctpwm_pkg::CTPWM_EVENT: begin
					if (cmp_hit) begin
						st_d.cnt_q = ctpwm_pkg::WORD_RESET;
						st_d.irq_q = 1'b1;
					end else begin
						// low byte carries into high byte
						st_d.cnt_q = st_q.cnt_q + 16'h0001;
					end
				end
				ctpwm_pkg::CTPWM_WAVE: begin
					st_d.cnt_q = st_q.cnt_q + 16'h0001;
					if (duty_hit != wrap) begin
						// both at once cancel: duty of all ones
						st_d.ff_q = !st_q.ff_q;
					end
					if (wrap) begin
						st_d.irq_q  = 1'b1;
						st_d.dact_q = st_q.dbuf_q;
					end
				end
				ctpwm_pkg::CTPWM_IDLE: begin
					st_d.cnt_q = st_q.cnt_q;
				end
			endcase
		end

		// register writes
		// duty bytes land in the buffer; the active copy moves at wrap while the wave runs
		if (wr_en) begin
			unique case (addr)
				ctpwm_pkg::ADDR_LOWER_CTL: st_d.lctl_q = wdata;
				ctpwm_pkg::ADDR_UPPER_CTL: begin
					st_d.uctl_q = wdata;
					// a stopping write leaves the flop alone
					if (!run) begin
						st_d.ff_q = wdata[ctpwm_pkg::UCTL_FF_INIT];
					end
				end
				ctpwm_pkg::ADDR_CMP_LO: st_d.cmp_q[7:0]  = wdata;
				ctpwm_pkg::ADDR_CMP_HI: st_d.cmp_q[15:8] = wdata;
				ctpwm_pkg::ADDR_DUTY_LO: st_d.dbuf_q[7:0]  = wdata;
				ctpwm_pkg::ADDR_DUTY_HI: st_d.dbuf_q[15:8] = wdata;
				default: st_d.lctl_q = st_q.lctl_q;
			endcase
		end

		// stopped: buffer passes straight into the active duty
		if (!run || mode != ctpwm_pkg::CTPWM_WAVE) begin
			st_d.dact_q = st_d.dbuf_q;
		end

		// reads answer one cycle later; unmapped reads as zero
		st_d.rdata_q = 8'h00;
		if (rd_en) begin
			unique case (addr)
				ctpwm_pkg::ADDR_LOWER_CTL: st_d.rdata_q = st_q.lctl_q;
				ctpwm_pkg::ADDR_UPPER_CTL: st_d.rdata_q = st_q.uctl_q;
				ctpwm_pkg::ADDR_CMP_LO:   st_d.rdata_q = st_q.cmp_q[7:0];
				ctpwm_pkg::ADDR_CMP_HI:   st_d.rdata_q = st_q.cmp_q[15:8];
				ctpwm_pkg::ADDR_DUTY_LO:  st_d.rdata_q = st_q.dact_q[7:0];
				ctpwm_pkg::ADDR_DUTY_HI:  st_d.rdata_q = st_q.dact_q[15:8];
				ctpwm_pkg::ADDR_COUNT_LO: st_d.rdata_q = st_q.cnt_q[7:0];
				ctpwm_pkg::ADDR_COUNT_HI: st_d.rdata_q = st_q.cnt_q[15:8];
				default: st_d.rdata_q = 8'h00;
			endcase
		end

		// pin registered from the next flop value
		// pin and flop share one edge, so they never skew
		st_d.pin_q = !st_d.ff_q;
	end

	// ======================================================
	// state register
	always_ff @(posedge clk) begin
		// mode, run and flop all come up cleared
		if (!reset_n) begin
			st_q         <= '0;
			st_q.pin_q   <= 1'b1; // flop cleared, pin high
			st_q.lctl_q  <= ctpwm_pkg::CTL_RESET;
			st_q.uctl_q  <= ctpwm_pkg::CTL_RESET;
			st_q.ff_q    <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	assign rdata     = st_q.rdata_q;
	assign pwm_out   = st_q.pin_q;
	assign match_irq = st_q.irq_q;

	// ======================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	match_clears_a: assert property (
		run && tick && cmp_hit && mode != ctpwm_pkg::CTPWM_WAVE
		|=> match_irq && st_q.cnt_q == 16'h0000)
		else $error("match did not clear the count");

	pin_inverse_a: assert property (
		pwm_out == !st_q.ff_q)
		else $error("wave pin not inverse of flop");

	stopped_hold_a: assert property (
		!run && !wr_upper |=> $stable(st_q.ff_q) && $stable(pwm_out))
		else $error("pin moved while stopped");

	reset_clear_a: assert property (disable iff (1'b0)
		!reset_n |=> !st_q.ff_q && pwm_out && !match_irq)
		else $error("reset left flop set");

	duty_shift_a: assert property (
		run && tick && wrap && mode == ctpwm_pkg::CTPWM_WAVE
		|=> st_q.dact_q == $past(st_q.dbuf_q) && match_irq)
		else $error("duty not transferred at overflow");

	duty_read_a: assert property (
		rd_en && addr == ctpwm_pkg::ADDR_DUTY_LO
		|=> rdata == $past(st_q.dact_q[7:0]))
		else $error("duty read not active value");

	event_step_a: assert property (
		run && mode == ctpwm_pkg::CTPWM_EVENT && ev_fall && !cmp_hit
		|=> st_q.cnt_q == $past(st_q.cnt_q) + 16'h0001)
		else $error("event edge not counted once");

	cmp_direct_a: assert property (
		wr_en && addr == ctpwm_pkg::ADDR_CMP_LO
		|=> st_q.cmp_q[7:0] == $past(wdata))
		else $error("compare write not immediate");

	wave_toggle_a: assert property (
		run && tick && duty_hit && !wrap
		&& mode == ctpwm_pkg::CTPWM_WAVE
		|=> st_q.ff_q != $past(st_q.ff_q))
		else $error("duty match did not toggle");

	stop_count_a: assert property (
		!run |=> st_q.cnt_q == 16'h0000 && !match_irq)
		else $error("stopped counter moved");

	// ======================================================
	// further checks on counting, pins and reads
	irq_single_a: assert property (
		match_irq |=> !match_irq)
		else $error("match interrupt longer than one cycle");

	wave_wrap_a: assert property (
		run && tick && wrap && mode == ctpwm_pkg::CTPWM_WAVE
		|=> st_q.cnt_q == 16'h0000)
		else $error("overflow did not clear the count");

	timer_tap_a: assert property (
		mode == ctpwm_pkg::CTPWM_TIMER && clk_sel[2] |-> !tick)
		else $error("wave-only tap ticked the timer");

	event_once_a: assert property (
		ev_fall |=> !ev_fall)
		else $error("one event edge counted twice");

	idle_hold_a: assert property (
		run && mode == ctpwm_pkg::CTPWM_IDLE
		|=> $stable(st_q.cnt_q) && !match_irq)
		else $error("idle mode moved the count");

	read_idle_a: assert property (
		!rd_en |=> rdata == 8'h00)
		else $error("read data stood past its cycle");

	stop_flop_keep_a: assert property (
		run && wr_upper && !wdata[ctpwm_pkg::UCTL_RUN] && !tick
		|=> st_q.ff_q == $past(st_q.ff_q))
		else $error("stopping write changed the flop");

	cmp_high_a: assert property (
		wr_en && addr == ctpwm_pkg::ADDR_CMP_HI
		|=> st_q.cmp_q[15:8] == $past(wdata))
		else $error("compare high write not immediate");

	duty_high_a: assert property (
		rd_en && addr == ctpwm_pkg::ADDR_DUTY_HI
		|=> rdata == $past(st_q.dact_q[15:8]))
		else $error("duty high read not active value");

	ctl_read_a: assert property (
		rd_en && addr == ctpwm_pkg::ADDR_UPPER_CTL
		|=> rdata == $past(st_q.uctl_q))
		else $error("control read wrong");

	timer_irq_c: cover property (
		mode == ctpwm_pkg::CTPWM_TIMER && match_irq);
	event_irq_c: cover property (
		mode == ctpwm_pkg::CTPWM_EVENT && match_irq);
	wave_wrap_c: cover property (
		mode == ctpwm_pkg::CTPWM_WAVE && match_irq ##1 !pwm_out);

	stop_reload_c: cover property (
		!run && wr_upper && wdata[ctpwm_pkg::UCTL_FF_INIT]);

	duty_hold_c: cover property (
		run && mode == ctpwm_pkg::CTPWM_WAVE && wr_en
		&& addr == ctpwm_pkg::ADDR_DUTY_HI);
endmodule
`default_nettype wire
